// File: logic/wdw_top.sv
// windowed watchdog with AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none
module wdw_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [wdw_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [wdw_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wdw_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [wdw_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic slow_clk,
  input wire logic debug_state,
  input wire logic idle_mode,
  input wire logic proc_reset,
  output logic wdt_irq,
  output logic fault_all_reset,
  output logic fault_proc_reset
);
  import wdw_pkg::*;

  // ----------------------------------------------------------------
  // pin inputs and prescaler
  // ----------------------------------------------------------------
  logic [2:0] pins_sync;
  logic slow_lvl;
  logic dbg_lvl;
  logic idle_lvl;
  logic tick;
  logic reload;

  wdw_sync #(.W(3)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({idle_mode, debug_state, slow_clk}),
    .sync_out(pins_sync)
  );

  assign slow_lvl = pins_sync[0];
  assign dbg_lvl = pins_sync[1];
  assign idle_lvl = pins_sync[2];

  wdw_prescaler u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .slow_lvl(slow_lvl),
    .restart(reload),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic do_write;
  logic wr_word;
  logic wr_mapped;

  assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_full_reg & ~bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_mapped = (aw_addr_reg == OFF_RESTART) | (aw_addr_reg == OFF_CONFIG) | (aw_addr_reg == OFF_FLAGS);
  // partial-width writes are ignored
  assign wr_word = do_write & (w_strb_reg == STRB_FULL);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end
    else if (do_write)
      aw_full_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
    else if (do_write)
      w_full_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic rd_take;
  logic flags_read;
  logic [DATA_W-1:0] config_reg;
  logic unf_reg;
  logic err_reg;

  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign rd_take = s_axi_arvalid & ~rvalid_reg;
  assign flags_read = rd_take & (s_axi_araddr == OFF_FLAGS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
      case (s_axi_araddr)
        OFF_RESTART: rdata_reg <= '0;
        OFF_CONFIG: rdata_reg <= config_reg;
        OFF_FLAGS:
        begin
          rdata_reg[UNF_BIT] <= unf_reg;
          rdata_reg[ERR_BIT] <= err_reg;
        end
        default: rresp_reg <= RESP_SLVERR;
      endcase
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // configuration, write once per processor reset
  // ----------------------------------------------------------------
  logic cfg_locked_reg;
  logic cfg_wr;
  logic restart_cmd;
  logic [CNT_W-1:0] reload_value;
  logic [CNT_W-1:0] delta_value;
  logic fault_irq_enable;
  logic fault_reset_enable;
  logic processor_only_reset;
  logic counter_disable;
  logic debug_halt;
  logic idle_halt;

  assign cfg_wr = wr_word & (aw_addr_reg == OFF_CONFIG) & ~cfg_locked_reg & ~proc_reset;
  assign restart_cmd = wr_word & (aw_addr_reg == OFF_RESTART) & ~proc_reset
    & (w_data_reg[KEY_HI:KEY_LO] == RESTART_KEY) & w_data_reg[RESTART_BIT];
  assign reload_value = config_reg[RELOAD_HI:RELOAD_LO];
  assign delta_value = config_reg[DELTA_HI:DELTA_LO];
  assign fault_irq_enable = config_reg[IRQ_EN_BIT];
  assign fault_reset_enable = config_reg[RST_EN_BIT];
  assign processor_only_reset = config_reg[PROC_ONLY_BIT];
  assign counter_disable = config_reg[DISABLE_BIT];
  assign debug_halt = config_reg[DBG_HALT_BIT];
  assign idle_halt = config_reg[IDLE_HALT_BIT];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      config_reg <= CONFIG_RESET;
      cfg_locked_reg <= 1'b0;
    end
    else if (proc_reset)
    begin
      config_reg <= CONFIG_RESET;
      cfg_locked_reg <= 1'b0;
    end
    else if (cfg_wr)
    begin
      config_reg <= w_data_reg & CONFIG_MASK;
      cfg_locked_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // down counter and window check
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] count_reg;
  logic in_window;
  logic restart_ok;
  logic window_err;
  logic running;
  logic underflow;

  assign in_window = count_reg <= delta_value;
  assign restart_ok = restart_cmd & in_window;
  assign window_err = restart_cmd & ~in_window;
  assign reload = restart_ok | cfg_wr | proc_reset;
  assign running = ~counter_disable & ~(debug_halt & dbg_lvl) & ~(idle_halt & idle_lvl);
  assign underflow = tick & running & (count_reg == CNT_ZERO) & ~reload;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_reg <= CONFIG_RESET[RELOAD_HI:RELOAD_LO];
    else if (proc_reset)
      count_reg <= CONFIG_RESET[RELOAD_HI:RELOAD_LO];
    else if (cfg_wr)
      count_reg <= w_data_reg[RELOAD_HI:RELOAD_LO];
    else if (restart_ok)
      count_reg <= reload_value;
    else if (tick && running)
      count_reg <= (count_reg == CNT_ZERO) ? reload_value : count_reg - CNT_ONE;
  end

  // ----------------------------------------------------------------
  // status flags, interrupt and fault request
  // ----------------------------------------------------------------
  logic unf_next;
  logic err_next;
  logic fault_reg;
  logic fault_next;

  // a new event wins over the read that clears
  assign unf_next = (unf_reg & ~flags_read) | underflow;
  assign err_next = (err_reg & ~flags_read) | window_err;
  assign fault_next = (fault_reg & ~flags_read) | ((underflow | window_err) & fault_reset_enable);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || proc_reset)
    begin
      unf_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else
    begin
      unf_reg <= unf_next;
      err_reg <= err_next;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || proc_reset)
    begin
      fault_reg <= 1'b0;
      wdt_irq <= 1'b0;
      fault_all_reset <= 1'b0;
      fault_proc_reset <= 1'b0;
    end
    else
    begin
      fault_reg <= fault_next;
      wdt_irq <= fault_irq_enable & (unf_next | err_next);
      fault_all_reset <= fault_next & ~processor_only_reset;
      fault_proc_reset <= fault_next & processor_only_reset;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bad_key_ignored: assert property (
    (wr_word && aw_addr_reg == OFF_RESTART && w_data_reg[KEY_HI:KEY_LO] != RESTART_KEY && !cfg_wr && !proc_reset)
    |=> !$rose(err_reg) && (count_reg == $past(count_reg) || $past(tick)))
    else $error("restart with wrong key had an effect");
  a_restart_reload: assert property (
    (restart_ok && !cfg_wr && !proc_reset) |=> count_reg == $past(reload_value))
    else $error("in-window restart did not reload");
  a_window_error: assert property (
    (window_err && !proc_reset) |=> err_reg && (count_reg == $past(count_reg) || $past(tick)))
    else $error("out-of-window restart not flagged");
  a_irq_gate: assert property (
    (!proc_reset && !fault_irq_enable) |=> !wdt_irq)
    else $error("interrupt raised while disabled");
  a_reset_scope: assert property (
    fault_all_reset |-> !fault_proc_reset && !$past(processor_only_reset))
    else $error("reset scope wrong");
  a_disabled_hold: assert property (
    (counter_disable && !reload) |=> count_reg == $past(count_reg))
    else $error("disabled counter moved");
  a_debug_freeze: assert property (
    (debug_halt && dbg_lvl && !reload) |=> count_reg == $past(count_reg))
    else $error("counter moved in debug halt");
  a_idle_freeze: assert property (
    (idle_halt && idle_lvl && !reload) |=> count_reg == $past(count_reg))
    else $error("counter moved in idle halt");
  a_unf_sticky: assert property (
    underflow && !proc_reset |=> unf_reg [*1] ##1 (unf_reg || $past(flags_read) || $past(proc_reset)))
    else $error("underflow flag lost");
  a_config_once: assert property (
    (cfg_locked_reg && !proc_reset) |=> config_reg == $past(config_reg))
    else $error("locked config changed");
  a_read_clears: assert property (
    (flags_read && !underflow && !window_err) |=> !fault_reg && !unf_reg && !err_reg)
    else $error("status read did not clear");

  c_restart: cover property (restart_ok);
  c_window_err: cover property (window_err);
  c_underflow: cover property (underflow ##[1:20] flags_read);
  c_config_write: cover property (cfg_wr);
endmodule : wdw_top
`default_nettype wire

// File: logic/wdw_pkg.sv
// constants for the windowed watchdog register block
package wdw_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 12;
  localparam int PRE_W = 7;
  localparam logic [PRE_W-1:0] PRE_LAST = 7'h7F;
  localparam logic [ADDR_W-1:0] OFF_RESTART = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] RESTART_KEY = 8'hA5;
  localparam int KEY_HI = 31;
  localparam int KEY_LO = 24;
  localparam int RESTART_BIT = 0;
  localparam int RELOAD_HI = 11;
  localparam int RELOAD_LO = 0;
  localparam int DELTA_HI = 27;
  localparam int DELTA_LO = 16;
  localparam int IRQ_EN_BIT = 12;
  localparam int RST_EN_BIT = 13;
  localparam int PROC_ONLY_BIT = 14;
  localparam int DISABLE_BIT = 15;
  localparam int DBG_HALT_BIT = 28;
  localparam int IDLE_HALT_BIT = 29;
  localparam int UNF_BIT = 0;
  localparam int ERR_BIT = 1;
  localparam logic [DATA_W-1:0] CONFIG_RESET = 32'h3FFF_2FFF;
  localparam logic [DATA_W-1:0] CONFIG_MASK = 32'h3FFF_FFFF;
  localparam logic [3:0] STRB_FULL = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
endpackage : wdw_pkg

// File: logic/wdw_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
`default_nettype none
module wdw_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          s1_reg[i] <= 1'b0;
          s2_reg[i] <= 1'b0;
          s3_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          s1_reg[i] <= async_in[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          // a change counts only when stages two and three agree
          if (s2_reg[i] == s3_reg[i])
            sync_out[i] <= s3_reg[i];
        end
      end
    end
  endgenerate
endmodule : wdw_sync
`default_nettype wire

// File: logic/wdw_prescaler.sv
// slow clock divide-by-128 prescaler with restart
`timescale 1ns/1ns
`default_nettype none
module wdw_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow_lvl,
  input wire logic restart,
  output logic tick
);
  import wdw_pkg::*;

  logic slow_prev_reg;
  logic [PRE_W-1:0] pre_reg;
  logic slow_rise;

  assign slow_rise = slow_lvl & ~slow_prev_reg;
  assign tick = slow_rise & (pre_reg == PRE_LAST) & ~restart;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      slow_prev_reg <= 1'b0;
    else
      slow_prev_reg <= slow_lvl;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pre_reg <= '0;
    else if (restart)
      pre_reg <= '0;
    else if (slow_rise)
      pre_reg <= pre_reg + 7'h01;
  end
endmodule : wdw_prescaler
`default_nettype wire

// File: tb/wdw_far_model.sv
// slow clock source standing in for the clock generator
`timescale 1ns/1ns
`default_nettype none
module wdw_far_model #(
  parameter int HALF = 4
) (
  input wire logic aclk,
  output logic slow_clk
);
  int cnt = 0;
  initial slow_clk = 1'b0;
  // free running, at least three fast cycles per level
  always @(posedge aclk)
  begin
    if (cnt == HALF - 1)
    begin
      cnt <= 0;
      slow_clk <= ~slow_clk;
    end
    else
      cnt <= cnt + 1;
  end
endmodule : wdw_far_model
`default_nettype wire

// File: tb/wdw_top_bench.sv
// self-checking bench for the windowed watchdog register block
`timescale 1ns/1ns
`default_nettype none
module wdw_top_bench;
  import wdw_pkg::*;
  typedef struct packed {logic [7:0] addr; logic [31:0] data; logic [1:0] resp;} wdw_row_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [3:0] wstrb = STRB_FULL;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic slow_clk, wdt_irq, fault_all_reset, fault_proc_reset;
  logic debug_state = 1'b0, idle_mode = 1'b0, proc_reset = 1'b0;
  logic [31:0] rd;
  int fail_count = 0;
  int n_compared = 0;
  wdw_row_s rows [4] = '{'{OFF_RESTART, 32'h0, RESP_OKAY}, '{OFF_CONFIG, CONFIG_RESET, RESP_OKAY},
                         '{OFF_FLAGS, 32'h0, RESP_OKAY}, '{8'h0C, 32'h0, RESP_SLVERR}};

  wdw_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .slow_clk(slow_clk),
    .debug_state(debug_state), .idle_mode(idle_mode), .proc_reset(proc_reset), .wdt_irq(wdt_irq),
    .fault_all_reset(fault_all_reset), .fault_proc_reset(fault_proc_reset));
  wdw_far_model #(.HALF(4)) far (.aclk(aclk), .slow_clk(slow_clk));

  initial
  begin
    forever #5 aclk = ~aclk;
  end

  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rdr

  task automatic wait_fault(input int lim);
    int n;
    n = 0;
    while (!(fault_all_reset === 1'b1 || fault_proc_reset === 1'b1) && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
    repeat (2) @(posedge aclk);
  endtask : wait_fault

  task automatic pulse_proc;
    @(posedge aclk);
    proc_reset <= 1'b1;
    @(posedge aclk);
    proc_reset <= 1'b0;
  endtask : pulse_proc

  task automatic report_and_stop;
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rdr(rows[i].addr, rd, rsp);
      chk("read data", rows[i].data, rd);
      chk("read resp", {30'h0, rows[i].resp}, {30'h0, rsp});
    end
    wr(8'h0C, 32'h0, rsp);
    chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    // short period, irq on, all-resets scope
    wr(OFF_CONFIG, 32'h0001_3001, rsp);
    wr(OFF_CONFIG, 32'h0000_0005, rsp);
    rdr(OFF_CONFIG, rd, rsp);
    chk("config after second write", 32'h0001_3001, rd);
    wait_fault(4000);
    chk("all-resets fault", 32'h1, {31'h0, fault_all_reset});
    chk("proc-only fault", 32'h0, {31'h0, fault_proc_reset});
    chk("irq on fault", 32'h1, {31'h0, wdt_irq});
    rdr(OFF_FLAGS, rd, rsp);
    chk("underflow flag", 32'h1, rd);
    repeat (2) @(posedge aclk);
    chk("irq after flag read", 32'h0, {31'h0, wdt_irq});
    chk("fault after flag read", 32'h0, {31'h0, fault_all_reset});
    // disabled, long reload, narrow window, processor-only scope
    pulse_proc;
    wstrb <= 4'h3;
    wr(OFF_CONFIG, 32'h0010_E800, rsp);
    wstrb <= STRB_FULL;
    chk("partial write resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    rdr(OFF_CONFIG, rd, rsp);
    chk("config after partial write", CONFIG_RESET, rd);
    wr(OFF_CONFIG, 32'h0010_E800, rsp);
    for (int i = 0; i < 2; i++)
    begin
      wr(OFF_RESTART, (i == 0) ? 32'h5A00_0001 : 32'hA500_0000, rsp);
    end
    rdr(OFF_FLAGS, rd, rsp);
    chk("flags after refused restarts", 32'h0, rd);
    wr(OFF_RESTART, 32'hA500_0001, rsp);
    repeat (2) @(posedge aclk);
    chk("proc-only fault", 32'h1, {31'h0, fault_proc_reset});
    chk("all-resets fault", 32'h0, {31'h0, fault_all_reset});
    chk("irq disabled", 32'h0, {31'h0, wdt_irq});
    rdr(OFF_FLAGS, rd, rsp);
    chk("window error flag", 32'h2, rd);
    // in-window restarts, then debug and idle halts
    pulse_proc;
    wr(OFF_CONFIG, 32'h3002_2002, rsp);
    for (int i = 0; i < 3; i++)
    begin
      repeat (2000) @(posedge aclk);
      wr(OFF_RESTART, 32'hA500_0001, rsp);
    end
    rdr(OFF_FLAGS, rd, rsp);
    chk("flags after in-window restarts", 32'h0, rd);
    for (int i = 0; i < 2; i++)
    begin
      wr(OFF_RESTART, 32'hA500_0001, rsp);
      if (i == 0)
        debug_state <= 1'b1;
      else
        idle_mode <= 1'b1;
      repeat (5000) @(posedge aclk);
      chk("fault while halted", 32'h0, {31'h0, fault_all_reset});
      debug_state <= 1'b0;
      idle_mode <= 1'b0;
      wait_fault(4000);
      chk("fault after halt ends", 32'h1, {31'h0, fault_all_reset});
      rdr(OFF_FLAGS, rd, rsp);
      chk("underflow flag", 32'h1, rd);
    end
    report_and_stop;
  end

  initial
  begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    report_and_stop;
  end
endmodule : wdw_top_bench
`default_nettype wire
